// ==== core/aom_pkg.sv ====
// constants of the result output bus multiplexer
// assumes one 200 MHz clock, synchronous pins and an AHB-Lite host
//
// Behaviour
// - format 0 drives all eighteen bits parallel
// - format 1, word low: upper sixteen bits
// - format 1, word high: bits 0,1 on lines 2,3
// - byte format 00: high byte, lines 3-9 float
// - byte format 01: middle byte on upper lines
// - byte format, word high: low byte, zeros
// - format 3 floats lines 1,2, serial pins
// - non-parallel: lines 0,1 become select inputs, line 2 in byte format only
// - reference power-down high disables internal reference
// - buffer power-down high disables reference buffer
// - buffer on, reference off: external bandgap used
// - drivers on only with chip select, read low
// - busy high during conversion, falls on latch
// - coding select picks binary or twos complement
package aom_pkg;

  // ---------------------------------------------------------------
  // result and format
  // ---------------------------------------------------------------
  localparam int          RES_W       = 18;
  localparam logic [1:0]  FMT_PAR18   = 2'h0;
  localparam logic [1:0]  FMT_WORD16  = 2'h1;
  localparam logic [1:0]  FMT_BYTE8   = 2'h2;
  localparam logic [1:0]  FMT_SERIAL  = 2'h3;
  localparam int          PIN_CODING  = 0;
  localparam int          PIN_WORD    = 1;
  localparam int          PIN_BYTE    = 2;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  OFS_SAMPLE  = 8'h00;
  localparam logic [7:0]  OFS_RESULT  = 8'h04;
  localparam logic [7:0]  OFS_STATUS  = 8'h08;
  localparam logic [7:0]  OFS_PINS    = 8'h0c;
  localparam int          ST_BUSY     = 0;
  localparam int          ST_FMT_LO   = 1;
  localparam int          ST_FMT_HI   = 2;
  localparam int          ST_REF_EN   = 3;
  localparam int          ST_BUF_EN   = 4;
  localparam int          ST_EXT_BG   = 5;
  localparam int          ST_EXT_REF  = 6;
  localparam int          ST_CODING   = 7;
  localparam int          ST_READ_ON  = 8;
  localparam logic [17:0] RESULT_RST  = 18'h00000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          CLK_PS      = 5000;
  localparam int          CONV_NS     = 700;
  localparam int          CONV_CYC    = (CONV_NS * 1000 + CLK_PS - 1)
                                        / CLK_PS;
  localparam int          CNT_W       = 8;

  typedef enum logic { CV_IDLE, CV_RUN } aom_conv_e;
  typedef enum logic [1:0] { AP_IDLE, AP_WAIT, AP_DONE } aom_ahb_e;

endpackage

// ==== core/aom_ref_ctl.sv ====
// reference and buffer power-down decode
// assumes the power-down pins are synchronous levels
module aom_ref_ctl (
  input  wire logic reference_powerdown,
  input  wire logic ref_buffer_powerdown,
  output logic      int_ref_en,
  output logic      ref_buf_en,
  output logic      ext_bandgap_mode,
  output logic      ext_ref_needed
);
  import aom_pkg::*;

  always_comb begin
    int_ref_en       = !reference_powerdown;
    ref_buf_en       = !ref_buffer_powerdown;
    ext_bandgap_mode = ref_buf_en && !int_ref_en;
    ext_ref_needed   = reference_powerdown;
  end

endmodule

// ==== core/aom_slice_mux.sv ====
// picks the result slice and the driven lines per format
// assumes coded result and selects are stable in the cycle
module aom_slice_mux (
  input  wire logic [1:0]  fmt,
  input  wire logic        word_select,
  input  wire logic        byte_select,
  input  wire logic [17:0] res,
  output logic      [17:0] line_val,
  output logic      [17:0] line_drv
);
  import aom_pkg::*;

  always_comb begin
    line_val = 18'h00000;
    line_drv = 18'h00000;
    unique case (fmt)
      FMT_PAR18: begin
        line_val = res;
        line_drv = 18'h3ffff;
      end
      FMT_WORD16: begin
        line_drv = 18'h3fffc;
        if (!word_select) begin
          line_val = {res[17:2], 2'h0};
        end else begin
          line_val = {14'h0000, res[1:0], 2'h0};
        end
      end
      FMT_BYTE8: begin
        line_drv = 18'h3fc00;
        unique case ({word_select, byte_select})
          2'h0: line_val = {res[17:10], 10'h000};
          2'h1: line_val = {res[9:2], 10'h000};
          2'h2: line_val = {6'h00, res[1:0], 10'h000};
          2'h3: line_val = {res[1:0], 16'h0000};
        endcase
      end
      FMT_SERIAL: begin
        line_drv = 18'h00000;
      end
    endcase
  end

endmodule

// ==== core/aom_out_mux.sv ====
// result output bus multiplexer: conversion hold, coding,
// slice selection, pin drivers and an AHB-Lite register slave
// assumes every pin is synchronous to mclk and one bus master
module aom_out_mux (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // host bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // parallel port
  input  wire logic        format_sel_hi,
  input  wire logic        format_sel_lo,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic [17:0] d_i,
  output logic      [17:0] d_o,
  output logic      [17:0] d_oe,
  output logic             busy,
  // reference control
  input  wire logic        reference_powerdown,
  input  wire logic        ref_buffer_powerdown,
  output logic             int_ref_en,
  output logic             ref_buf_en,
  output logic             bandgap_buffer_input_ext,
  output logic             ext_ref_needed
);
  import aom_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    aom_ahb_e    ph;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] rdata;
    aom_conv_e   cv;
    logic [CNT_W-1:0] cnt;
    logic [17:0] sample;
    logic [17:0] result;
    logic        busy;
    logic [17:0] dout;
    logic [17:0] doe;
    logic        ref_en;
    logic        buf_en;
    logic        ext_bg;
    logic        ext_ref;
  } aom_state_s;

  aom_state_s st_r;
  aom_state_s st_nxt;

  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);

  // ---------------------------------------------------------------
  // pin decode
  // ---------------------------------------------------------------
  logic [1:0]  fmt;
  logic        parallel18;
  logic        coding_select;
  logic        word_select;
  logic        byte_select;
  logic        read_on;
  logic [17:0] coded;
  logic [17:0] line_val;
  logic [17:0] line_drv;
  logic        ref_en_c;
  logic        buf_en_c;
  logic        ext_bg_c;
  logic        ext_ref_c;

  assign fmt        = {format_sel_hi, format_sel_lo};
  assign parallel18 = (fmt == FMT_PAR18);
  // low lines turn into select inputs outside 18-bit mode
  assign coding_select = parallel18 ? 1'b1 : d_i[PIN_CODING];
  assign word_select   = parallel18 ? 1'b0 : d_i[PIN_WORD];
  assign byte_select   = (fmt == FMT_BYTE8) ? d_i[PIN_BYTE]
                                            : 1'b0;
  assign read_on       = !cs_n && !rd_n;

  // high coding select keeps straight binary; low flips the msb
  always_comb begin
    coded = st_r.result;
    if (!parallel18 && !coding_select) begin
      coded[17] = !st_r.result[17];
    end
  end

  aom_slice_mux u_slice (
    .fmt         (fmt),
    .word_select (word_select),
    .byte_select (byte_select),
    .res         (coded),
    .line_val    (line_val),
    .line_drv    (line_drv)
  );

  aom_ref_ctl u_ref (
    .reference_powerdown  (reference_powerdown),
    .ref_buffer_powerdown (ref_buffer_powerdown),
    .int_ref_en           (ref_en_c),
    .ref_buf_en           (buf_en_c),
    .ext_bandgap_mode     (ext_bg_c),
    .ext_ref_needed       (ext_ref_c)
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic take;
  logic wr_sample;

  assign take      = hsel && htrans[1] && hready;
  assign wr_sample = (st_r.ph == AP_WAIT) && st_r.wr
                     && (st_r.addr == OFS_SAMPLE);

  function automatic logic [31:0] read_word(
    input logic [7:0]  a,
    input aom_state_s  s,
    input logic [1:0]  f,
    input logic        cod,
    input logic        rdo
  );
    logic [31:0] w;
    w = 32'h00000000;
    unique case (a)
      OFS_SAMPLE: w = {14'h0000, s.sample};
      OFS_RESULT: w = {14'h0000, s.result};
      OFS_STATUS: begin
        w[ST_BUSY]    = s.busy;
        w[ST_FMT_LO]  = f[0];
        w[ST_FMT_HI]  = f[1];
        w[ST_REF_EN]  = s.ref_en;
        w[ST_BUF_EN]  = s.buf_en;
        w[ST_EXT_BG]  = s.ext_bg;
        w[ST_EXT_REF] = s.ext_ref;
        w[ST_CODING]  = cod;
        w[ST_READ_ON] = rdo;
      end
      OFS_PINS:   w = {14'h0000, s.dout};
      default:    w = 32'h00000000;
    endcase
    return w;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;

    // bus phase: one wait state on every access
    unique case (st_r.ph)
      AP_IDLE, AP_DONE: begin
        if (take) begin
          st_nxt.ph   = AP_WAIT;
          st_nxt.wr   = hwrite;
          st_nxt.addr = {haddr[7:2], 2'h0};
        end else begin
          st_nxt.ph = AP_IDLE;
        end
      end
      AP_WAIT: begin
        st_nxt.ph = AP_DONE;
        if (!st_r.wr) begin
          st_nxt.rdata = read_word(st_r.addr, st_r, fmt,
                                   coding_select, read_on);
        end
      end
      default: st_nxt.ph = AP_IDLE;
    endcase

    // conversion: a sample write starts it, ignored while busy
    unique case (st_r.cv)
      CV_IDLE: begin
        if (wr_sample) begin
          st_nxt.cv     = CV_RUN;
          st_nxt.sample = hwdata[17:0];
          st_nxt.cnt    = CONV_LAST;
          st_nxt.busy   = 1'b1;
        end
      end
      CV_RUN: begin
        if (st_r.cnt == '0) begin
          st_nxt.cv     = CV_IDLE;
          st_nxt.result = st_r.sample;
          st_nxt.busy   = 1'b0;
        end else begin
          st_nxt.cnt = st_r.cnt - CNT_W'(1);
        end
      end
    endcase

    // pin drivers follow the read strobes one cycle later
    st_nxt.dout = line_val;
    st_nxt.doe  = read_on ? line_drv : 18'h00000;

    st_nxt.ref_en  = ref_en_c;
    st_nxt.buf_en  = buf_en_c;
    st_nxt.ext_bg  = ext_bg_c;
    st_nxt.ext_ref = ext_ref_c;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r.ph      <= AP_IDLE;
      st_r.wr      <= 1'b0;
      st_r.addr    <= 8'h00;
      st_r.rdata   <= 32'h00000000;
      st_r.cv      <= CV_IDLE;
      st_r.cnt     <= '0;
      st_r.sample  <= RESULT_RST;
      st_r.result  <= RESULT_RST;
      st_r.busy    <= 1'b0;
      st_r.dout    <= 18'h00000;
      st_r.doe     <= 18'h00000;
      st_r.ref_en  <= 1'b0;
      st_r.buf_en  <= 1'b0;
      st_r.ext_bg  <= 1'b0;
      st_r.ext_ref <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hrdata    = st_r.rdata;
  assign hreadyout = (st_r.ph != AP_WAIT);
  assign hresp     = 1'b0;
  assign d_o       = st_r.dout;
  assign d_oe      = st_r.doe;
  assign busy      = st_r.busy;
  assign int_ref_en               = st_r.ref_en;
  assign ref_buf_en               = st_r.buf_en;
  assign bandgap_buffer_input_ext = st_r.ext_bg;
  assign ext_ref_needed           = st_r.ext_ref;

endmodule

// ==== dv/aom_out_mux_sva.sv ====
// checker for the result output pins and reference control
// assumes binding to aom_out_mux, one clock, ce held high
module aom_out_mux_sva
  import aom_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        format_sel_hi,
  input wire logic        format_sel_lo,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic [17:0] d_i,
  input wire logic [17:0] d_o,
  input wire logic [17:0] d_oe,
  input wire logic        busy,
  input wire logic        reference_powerdown,
  input wire logic        ref_buffer_powerdown,
  input wire logic        int_ref_en,
  input wire logic        ref_buf_en,
  input wire logic        bandgap_buffer_input_ext
);
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  logic       rd_on;
  logic [1:0] fmt;
  logic [7:0] busy_cnt_r;
  assign rd_on = !cs_n && !rd_n;
  assign fmt   = {format_sel_hi, format_sel_lo};
  always_ff @(posedge mclk) begin
    if (rst || !busy) busy_cnt_r <= 8'h00;
    else busy_cnt_r <= busy_cnt_r + 8'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // -------------------------------------------------------------
  // properties
  // -------------------------------------------------------------
  property p_gate;
    (cs_n || rd_n) |=> d_oe == 18'h00000;
  endproperty
  a_gate: assert property (p_gate)
    else $error("drivers on with no read");
  property p_par;
    (rd_on && fmt == FMT_PAR18) |=> d_oe == 18'h3ffff;
  endproperty
  a_par: assert property (p_par)
    else $error("parallel lines not all driven");
  property p_word;
    (rd_on && fmt == FMT_WORD16) |=> d_oe == 18'h3fffc;
  endproperty
  a_word: assert property (p_word)
    else $error("word lines wrong");
  property p_low_word;
    (rd_on && fmt == FMT_WORD16 && d_i[1]) |=> d_o[17:4] == 14'h0000;
  endproperty
  a_low_word: assert property (p_low_word)
    else $error("low word upper lines not zero");
  property p_byte;
    (rd_on && fmt == FMT_BYTE8) |=> d_oe == 18'h3fc00;
  endproperty
  a_byte: assert property (p_byte)
    else $error("byte lines wrong");
  property p_low_byte;
    (rd_on && fmt == FMT_BYTE8 && d_i[1]) |=> d_o[15:12] == 4'h0;
  endproperty
  a_low_byte: assert property (p_low_byte)
    else $error("low byte fill not zero");
  property p_serial;
    (rd_on && fmt == FMT_SERIAL) |=> d_oe[2:1] == 2'h0;
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial mode drives lines 1-2");
  property p_sel_in;
    (rd_on && fmt != FMT_PAR18) |=> !d_oe[0];
  endproperty
  a_sel_in: assert property (p_sel_in)
    else $error("select line 0 driven");
  property p_ref;
    !rst |=> int_ref_en != $past(reference_powerdown);
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference enable wrong");
  property p_buf;
    !rst |=> ref_buf_en != $past(ref_buffer_powerdown);
  endproperty
  a_buf: assert property (p_buf)
    else $error("buffer enable wrong");
  property p_bg;
    (!rst && reference_powerdown && !ref_buffer_powerdown)
      |=> bandgap_buffer_input_ext;
  endproperty
  a_bg: assert property (p_bg)
    else $error("external bandgap mode missing");
  property p_busy;
    $fell(busy) |-> busy_cnt_r == 8'(CONV_CYC);
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy length wrong");
endmodule

bind aom_out_mux aom_out_mux_sva aom_out_mux_sva_inst (
  .mclk(mclk), .rst(rst), .format_sel_hi(format_sel_hi),
  .format_sel_lo(format_sel_lo), .cs_n(cs_n), .rd_n(rd_n), .d_i(d_i),
  .d_o(d_o), .d_oe(d_oe), .busy(busy),
  .reference_powerdown(reference_powerdown),
  .ref_buffer_powerdown(ref_buffer_powerdown), .int_ref_en(int_ref_en),
  .ref_buf_en(ref_buf_en),
  .bandgap_buffer_input_ext(bandgap_buffer_input_ext));

// ==== dv/aom_host_model.sv ====
// host model: select pins, read strobes and power-down pins
// assumes requests change just after a rising edge of mclk
module aom_host_model (
  input  wire logic        mclk,
  input  wire logic [1:0]  fmt_req,
  input  wire logic        word_req,
  input  wire logic        byte_req,
  input  wire logic        coding_req,
  input  wire logic        rd_req,
  input  wire logic        refpd_req,
  input  wire logic        bufpd_req,
  output logic             format_sel_hi,
  output logic             format_sel_lo,
  output logic             cs_n,
  output logic             rd_n,
  output logic      [17:0] d_i,
  output logic             reference_powerdown,
  output logic             ref_buffer_powerdown
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0]  sel_r;
  logic [14:0] junk_r = 15'h2aaa;
  always_ff @(posedge mclk) begin
    junk_r <= ~junk_r;
    cs_n   <= !rd_req;
    rd_n   <= !rd_req;
    // selects only move between reads
    if (!rd_req) begin
      {format_sel_hi, format_sel_lo} <= fmt_req;
      sel_r <= {byte_req, word_req, coding_req};
    end
    reference_powerdown  <= refpd_req;
    // buffer stays on while the internal reference is used
    ref_buffer_powerdown <= bufpd_req && refpd_req;
  end
  // unused data lines toggle so stale values never match
  assign d_i = {junk_r, sel_r};
endmodule

// ==== dv/tb_top.sv ====
// testbench for aom_out_mux: bus registers, pin slices, references
// assumes aom_host_model on the pin side and ce tied high
module tb_top
  import aom_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, hsel, hwrite, rd_req, word_req, byte_req, coding_req;
  logic refpd_req, bufpd_req;
  logic [1:0] htrans, fmt_req;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, rd;
  logic [17:0] res;
  wire logic [31:0] hrdata;
  wire logic [17:0] d_i, d_o, d_oe;
  wire logic hreadyout, hsel_hi, hsel_lo, cs_n, rd_n, busy, pdr, pdb;
  wire logic hresp;
  wire logic int_ref_en, ref_buf_en, bg_ext, ext_ref_needed;
  int failures, n_tests, i, n;

  aom_host_model aom_host_model_inst (.mclk(mclk), .fmt_req(fmt_req),
    .word_req(word_req), .byte_req(byte_req), .coding_req(coding_req),
    .rd_req(rd_req), .refpd_req(refpd_req), .bufpd_req(bufpd_req),
    .format_sel_hi(hsel_hi), .format_sel_lo(hsel_lo), .cs_n(cs_n),
    .rd_n(rd_n), .d_i(d_i), .reference_powerdown(pdr),
    .ref_buffer_powerdown(pdb));
  aom_out_mux aom_out_mux_inst (.mclk(mclk), .rst(rst), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .format_sel_hi(hsel_hi),
    .format_sel_lo(hsel_lo), .cs_n(cs_n), .rd_n(rd_n), .d_i(d_i),
    .d_o(d_o), .d_oe(d_oe), .busy(busy), .reference_powerdown(pdr),
    .ref_buffer_powerdown(pdb), .int_ref_en(int_ref_en),
    .ref_buf_en(ref_buf_en), .bandgap_buffer_input_ext(bg_ext),
    .ext_ref_needed(ext_ref_needed));

  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge mclk);
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(posedge mclk);
      k++;
    end while (!hreadyout && k < 40);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge mclk);
      k++;
    end while (!hreadyout && k < 40);
    q = hrdata;
    if (k >= 40) begin
      failures++;
      end_sim();
    end
  endtask
  task automatic pin(input logic [1:0] f, input logic w, b, c);
    logic [17:0] r, ev, eo;
    @(posedge mclk);
    rd_req     <= 1'b0;
    fmt_req    <= f;
    word_req   <= w;
    byte_req   <= b;
    coding_req <= c;
    @(posedge mclk);
    rd_req <= 1'b1;
    repeat (3) @(posedge mclk);
    r  = (f == FMT_PAR18 || c) ? res : {~res[17], res[16:0]};
    eo = f == 2'h0 ? 18'h3ffff : f == 2'h1 ? 18'h3fffc :
         f == 2'h2 ? 18'h3fc00 : 18'h00000;
    case (f)
      2'h0: ev = r;
      2'h1: ev = w ? {14'h0000, r[1:0], 2'h0} : {r[17:2], 2'h0};
      2'h2: case ({w, b})
        2'h0: ev = {r[17:10], 10'h000};
        2'h1: ev = {r[9:2], 10'h000};
        2'h2: ev = {6'h00, r[1:0], 10'h000};
        default: ev = {r[1:0], 16'h0000};
      endcase
      default: ev = 18'h00000;
    endcase
    chk("d_oe", {14'h0, eo}, {14'h0, d_oe});
    chk("d_o", {14'h0, ev & eo}, {14'h0, d_o & eo});
  endtask

  // -------------------------------------------------------------
  // sequence
  // -------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    repeat (50000) @(posedge mclk);
    failures++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    {hsel, hwrite, rd_req, word_req, byte_req, refpd_req, bufpd_req} = '0;
    {htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    fmt_req = FMT_WORD16;
    coding_req = 1'b1;
    repeat (10) @(posedge mclk);
    rst  <= 1'b0;
    hsel <= 1'b1;
    ahb(1'b1, OFS_SAMPLE, 32'hfff6d3a5, rd);
    res = 18'h2d3a5;
    ahb(1'b0, OFS_STATUS, 32'h0, rd);
    chk("busy bit", 32'h1, {31'h0, rd[ST_BUSY]});
    ahb(1'b1, OFS_SAMPLE, 32'h00011111, rd);
    n = 0;
    while (busy && n < 300) begin
      @(posedge mclk);
      n++;
    end
    chk("busy ends", 32'h1, {31'h0, n < 300});
    ahb(1'b0, OFS_RESULT, 32'h0, rd);
    chk("result", {14'h0, res}, rd);
    ahb(1'b1, OFS_RESULT, 32'h3ffff, rd);
    ahb(1'b0, OFS_RESULT, 32'h0, rd);
    chk("result ro", {14'h0, res}, rd);
    ahb(1'b0, 8'h40, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
    for (i = 0; i < 16; i++) pin(i[3:2], i[1], i[0], 1'b1);
    pin(FMT_WORD16, 1'b0, 1'b0, 1'b0);
    pin(FMT_BYTE8, 1'b0, 1'b0, 1'b0);
    @(posedge mclk);
    rd_req <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("d_oe idle", 32'h0, {14'h0, d_oe});
    for (i = 0; i < 3; i++) begin
      refpd_req <= i != 0;
      bufpd_req <= i == 2;
      repeat (4) @(posedge mclk);
      chk("ref_en", {31'h0, i == 0}, {31'h0, int_ref_en});
      chk("buf_en", {31'h0, i != 2}, {31'h0, ref_buf_en});
      chk("bg_ext", {31'h0, i == 1}, {31'h0, bg_ext});
      chk("ext_ref", {31'h0, i != 0}, {31'h0, ext_ref_needed});
    end
    end_sim();
  end
endmodule
